/* rtl/ldc_cfg.svh */
// Purpose: Constants for the dither configuration register bank
// Assumes: Included by the package and the design file
// Notes:   Offsets are register numbers, used directly as word addresses
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LDC_ADDR_W 8
`define LDC_DATA_W 16
`define LDC_OFF_CONTROL 8'h59
`define LDC_OFF_RATE 8'h5A
`define LDC_OFF_FM 8'h5B
`define LDC_OFF_AM 8'h5C
`define LDC_OFF_STATUS 8'h70
`define LDC_OFF_IRQ_STAT 8'h71
`define LDC_OFF_IRQ_MASK 8'h72
`define LDC_OFF_NV_CTRL 8'h73

// ----------------------------------------------------------------
// Fields of the control word
// ----------------------------------------------------------------
`define LDC_ON_BIT 1
`define LDC_WAVE_HI 5
`define LDC_WAVE_LO 4
`define LDC_CTRL_MASK 16'h0032
`define LDC_WAVE_SINE 2'h0
`define LDC_WAVE_TRI 2'h1

// ----------------------------------------------------------------
// Supported ranges and rate step
// ----------------------------------------------------------------
`define LDC_RATE_MIN 16'h000A
`define LDC_RATE_MAX 16'h00C8
`define LDC_RATE_STEP 16'h0005
`define LDC_FM_MAX 16'h000A
`define LDC_AM_MAX 16'h0064
`define LDC_SBS_RATE 16'h001E

// ----------------------------------------------------------------
// Reset values (stand in for stored defaults)
// ----------------------------------------------------------------
`define LDC_RST_CONTROL 16'h0000
`define LDC_RST_RATE 16'h0064
`define LDC_RST_FM 16'h0000
`define LDC_RST_AM 16'h0032

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define LDC_IRQ_W 3
`define LDC_IRQ_ERR 0
`define LDC_IRQ_PEND 1
`define LDC_IRQ_SAVE 2
`define LDC_ZERO16 16'h0000
`define LDC_ONE16 16'h0001
`define LDC_PEND_CYC 4'h8
`define LDC_PEND_ONE 4'h1
`define LDC_PEND_ZERO 4'h0
`endif

/* rtl/ldc_pkg.sv */
// Purpose: Types for the dither configuration register bank
// Assumes: ldc_cfg.svh on the include path
// Notes:   Error codes are a local encoding of the error field
`include "ldc_cfg.svh"
package ldc_pkg;

    typedef enum logic [2:0] {
        LDC_ERR_OK,
        LDC_ERR_READ_ONLY,
        LDC_ERR_IN_PROGRESS,
        LDC_ERR_EXEC_FAIL,
        LDC_ERR_ENABLED,
        LDC_ERR_UNMAPPED
    } ldc_err_t;

    typedef enum logic [0:0] {
        LDC_IDLE,
        LDC_PENDING
    } ldc_pend_t;

endpackage

/* rtl/laser_dither_config.sv */
// Purpose: Dither enable, waveform, rate, FM and AM register bank
// Assumes: Host uses the plain strobe port, one access per cycle
// Notes:   Read data valid the cycle after the read strobe only
`timescale 1ns/1ns
`default_nettype none
`include "ldc_cfg.svh"

module ldc_laser_dither_config
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [`LDC_ADDR_W-1:0] regAddr,
    input wire logic [`LDC_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`LDC_DATA_W-1:0] regRdata,
    output logic respValid,
    output logic respError,
    output logic [2:0] respCause,
    output logic respPending,
    // Non-volatile store
    input wire logic [`LDC_DATA_W-1:0] nvControl,
    input wire logic [`LDC_DATA_W-1:0] nvRate,
    input wire logic [`LDC_DATA_W-1:0] nvFm,
    input wire logic [`LDC_DATA_W-1:0] nvAm,
    output logic nvSave,
    // Dither engine
    output logic ditherOn,
    output logic [1:0] waveSelect,
    output logic [`LDC_DATA_W-1:0] toneRate,
    output logic [`LDC_DATA_W-1:0] suppressRate,
    output logic [`LDC_DATA_W-1:0] fmDeviation,
    output logic [`LDC_DATA_W-1:0] amDepth,
    output logic txOutputHold,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [`LDC_DATA_W-1:0] control;
        logic [`LDC_DATA_W-1:0] rate;
        logic [`LDC_DATA_W-1:0] fm;
        logic [`LDC_DATA_W-1:0] am;
        logic [`LDC_DATA_W-1:0] pendControl;
        logic [`LDC_DATA_W-1:0] pendRate;
        logic pendIsRate;
        ldc_pend_t pend;
        logic [3:0] pendCnt;
        logic [`LDC_DATA_W-1:0] pendId;
        logic loaded;
        logic [`LDC_DATA_W-1:0] rdata;
        logic valid;
        logic error;
        ldc_err_t cause;
        logic pending;
        logic save;
        logic [`LDC_IRQ_W-1:0] irqStat;
        logic [`LDC_IRQ_W-1:0] irqMask;
        logic irq;
    } ldc_state_t;

    ldc_state_t st;
    ldc_state_t next_st;
    logic rstSync1;
    logic rstSync2;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Nearest supported rate step
    function automatic logic [`LDC_DATA_W-1:0] snapRate(
        input logic [`LDC_DATA_W-1:0] req);
        logic [`LDC_DATA_W-1:0] lowStep;
        logic [`LDC_DATA_W-1:0] rem;
        lowStep = req - (req % `LDC_RATE_STEP);
        rem = req % `LDC_RATE_STEP;
        if ((rem << 1) >= `LDC_RATE_STEP) begin
            lowStep = lowStep + `LDC_RATE_STEP;
        end
        if (lowStep < `LDC_RATE_MIN) begin
            lowStep = `LDC_RATE_MIN;
        end
        if (lowStep > `LDC_RATE_MAX) begin
            lowStep = `LDC_RATE_MAX;
        end
        return lowStep;
    endfunction

    function automatic logic isOn(input logic [`LDC_DATA_W-1:0] ctl);
        return ctl[`LDC_ON_BIT];
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [`LDC_DATA_W-1:0] wd;
        logic reject;
        logic busy;
        logic [`LDC_IRQ_W-1:0] setBits;
        logic [`LDC_IRQ_W-1:0] clrBits;
        wd = regWdata;
        reject = 1'b0;
        setBits = {`LDC_IRQ_W{1'b0}};
        clrBits = {`LDC_IRQ_W{1'b0}};
        busy = (st.pend == LDC_PENDING);
        next_st = st;
        next_st.valid = 1'b0;
        next_st.error = 1'b0;
        next_st.cause = LDC_ERR_OK;
        next_st.pending = 1'b0;
        next_st.save = 1'b0;
        next_st.rdata = `LDC_ZERO16;

        // Stored defaults loaded once after reset
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.control = nvControl & `LDC_CTRL_MASK;
            next_st.rate = snapRate(nvRate);
            next_st.fm = nvFm;
            next_st.am = nvAm;
        end

        // Deferred write completes
        if (busy) begin
            next_st.pendCnt = st.pendCnt - `LDC_PEND_ONE;
            if (st.pendCnt == `LDC_PEND_ONE) begin
                next_st.pend = LDC_IDLE;
                if (st.pendIsRate) begin
                    next_st.rate = st.pendRate;
                end else begin
                    next_st.control = st.pendControl;
                end
            end
        end

        if (regRead) begin
            next_st.valid = 1'b1;
            unique case (regAddr)
                `LDC_OFF_CONTROL: next_st.rdata = st.control;
                `LDC_OFF_RATE: next_st.rdata = st.rate;
                `LDC_OFF_FM: next_st.rdata = st.fm;
                `LDC_OFF_AM: next_st.rdata = st.am;
                `LDC_OFF_STATUS: next_st.rdata =
                    {13'h0000, st.pendIsRate, busy, isOn(st.control)};
                `LDC_OFF_IRQ_STAT: next_st.rdata = {13'h0000, st.irqStat};
                `LDC_OFF_IRQ_MASK: next_st.rdata = {13'h0000, st.irqMask};
                `LDC_OFF_NV_CTRL: next_st.rdata = `LDC_ZERO16;
                default: begin
                    next_st.error = 1'b1;
                    next_st.cause = LDC_ERR_UNMAPPED;
                end
            endcase
        end

        if (regWrite) begin
            next_st.valid = 1'b1;
            next_st.rdata = wd;
            unique case (regAddr)
                `LDC_OFF_CONTROL: begin
                    if (busy) begin
                        reject = 1'b1;
                        next_st.cause = LDC_ERR_IN_PROGRESS;
                    end else if ((wd & ~`LDC_CTRL_MASK) != `LDC_ZERO16 ||
                        wd[`LDC_WAVE_HI:`LDC_WAVE_LO] > `LDC_WAVE_TRI) begin
                        reject = 1'b1;
                        next_st.cause = LDC_ERR_EXEC_FAIL;
                    end else begin
                        // enable changes are deferred, never blank light
                        next_st.pend = LDC_PENDING;
                        next_st.pendIsRate = 1'b0;
                        next_st.pendControl = wd;
                        next_st.pendCnt = `LDC_PEND_CYC;
                        next_st.pendId = st.pendId + `LDC_ONE16;
                        next_st.rdata = st.pendId + `LDC_ONE16;
                        next_st.pending = 1'b1;
                    end
                end
                `LDC_OFF_RATE, `LDC_OFF_FM, `LDC_OFF_AM: begin
                    if (isOn(st.control) ||
                        (busy && isOn(st.pendControl) && !st.pendIsRate)) begin
                        reject = 1'b1;
                        next_st.cause = LDC_ERR_ENABLED;
                    end else if (regAddr == `LDC_OFF_RATE) begin
                        if (busy) begin
                            reject = 1'b1;
                            next_st.cause = LDC_ERR_IN_PROGRESS;
                        end else begin
                            next_st.pend = LDC_PENDING;
                            next_st.pendIsRate = 1'b1;
                            next_st.pendRate = snapRate(wd);
                            next_st.pendCnt = `LDC_PEND_CYC;
                            next_st.pendId = st.pendId + `LDC_ONE16;
                            next_st.rdata = st.pendId + `LDC_ONE16;
                            next_st.pending = 1'b1;
                        end
                    end else if (regAddr == `LDC_OFF_FM) begin
                        if (wd > `LDC_FM_MAX) begin
                            reject = 1'b1;
                            next_st.cause = LDC_ERR_EXEC_FAIL;
                        end else begin
                            next_st.fm = wd;
                        end
                    end else begin
                        if (wd > `LDC_AM_MAX) begin
                            reject = 1'b1;
                            next_st.cause = LDC_ERR_EXEC_FAIL;
                        end else begin
                            next_st.am = wd;
                        end
                    end
                end
                `LDC_OFF_STATUS: begin
                    reject = 1'b1;
                    next_st.cause = LDC_ERR_READ_ONLY;
                end
                `LDC_OFF_IRQ_STAT: ;
                `LDC_OFF_IRQ_MASK:
                    next_st.irqMask = wd[`LDC_IRQ_W-1:0];
                `LDC_OFF_NV_CTRL: begin
                    if (wd[0]) begin
                        next_st.save = 1'b1;
                    end
                end
                default: begin
                    reject = 1'b1;
                    next_st.cause = LDC_ERR_UNMAPPED;
                end
            endcase
            if (reject) begin
                next_st.error = 1'b1;
                next_st.rdata = `LDC_ZERO16;
                next_st.pending = 1'b0;
            end
        end

        // Sticky events; set wins over write-one-to-clear
        setBits = {next_st.save,
            busy && st.pendCnt == `LDC_PEND_ONE,
            reject};
        clrBits = (regWrite && regAddr == `LDC_OFF_IRQ_STAT) ?
            wd[`LDC_IRQ_W-1:0] : {`LDC_IRQ_W{1'b0}};
        next_st.irqStat = (st.irqStat & ~clrBits) | setBits;
        next_st.irq = |(next_st.irqStat & next_st.irqMask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstSync2) begin
        if (!rstSync2) begin
            st <= '0;
            st.control <= `LDC_RST_CONTROL;
            st.rate <= `LDC_RST_RATE;
            st.fm <= `LDC_RST_FM;
            st.am <= `LDC_RST_AM;
            st.pend <= LDC_IDLE;
            st.cause <= LDC_ERR_OK;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Engine outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstSync2) begin
        if (!rstSync2) begin
            ditherOn <= 1'b0;
            waveSelect <= `LDC_WAVE_SINE;
            toneRate <= `LDC_RST_RATE;
            suppressRate <= `LDC_SBS_RATE;
            fmDeviation <= `LDC_RST_FM;
            amDepth <= `LDC_RST_AM;
            txOutputHold <= 1'b1;
        end else begin
            ditherOn <= isOn(next_st.control);
            waveSelect <= next_st.control[`LDC_WAVE_HI:`LDC_WAVE_LO];
            toneRate <= next_st.rate;
            // Over-constrained: suppression falls back to its own rate
            suppressRate <= (next_st.am != `LDC_ZERO16 &&
                next_st.fm != `LDC_ZERO16) ?
                `LDC_SBS_RATE : next_st.rate;
            fmDeviation <= next_st.fm;
            amDepth <= next_st.am;
            txOutputHold <= 1'b1;
        end
    end

    assign regRdata = st.rdata;
    assign respValid = st.valid;
    assign respError = st.error;
    assign respCause = st.cause;
    assign respPending = st.pending;
    assign nvSave = st.save;
    assign irq = st.irq;

endmodule // ldc_laser_dither_config

`default_nettype wire

/* test/ldc_host_model.sv */
// Purpose: Host side of the register port
// Assumes: One access at a time, strobes one cycle long
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ns
`default_nettype none
module ldc_host_model (
    // Clock
    input wire logic clk_sys,
    // Requests
    output logic [7:0] regAddr,
    output logic [15:0] regWdata,
    output logic regWrite,
    output logic regRead,
    // Responses
    input wire logic [15:0] regRdata,
    input wire logic respValid,
    input wire logic respError,
    input wire logic [2:0] respCause,
    input wire logic respPending
);
    logic [15:0] gotData;
    logic [2:0] gotCause;
    logic gotValid, gotErr, gotPend;
    initial begin
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // Answer is sampled in the one cycle it stands
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= wr;
        regRead <= !wr;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
        #1;
        gotValid = respValid;
        gotErr = respError;
        gotCause = respCause;
        gotPend = respPending;
        gotData = regRdata;
    endtask
endmodule // ldc_host_model
`default_nettype wire

/* test/ldc_laser_dither_config_properties.sv */
// Purpose: Port assertions for the dither register bank
// Assumes: Bound to the top module, sees its ports only
// Notes:   Deferred writes are judged by the bench
`timescale 1ns/1ns
`default_nettype none
`include "ldc_cfg.svh"
module ldc_properties
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic respValid,
    input wire logic respError,
    input wire logic [2:0] respCause,
    // Dither engine
    input wire logic ditherOn,
    input wire logic [1:0] waveSelect,
    input wire logic [15:0] toneRate,
    input wire logic [15:0] suppressRate,
    input wire logic [15:0] fmDeviation,
    input wire logic [15:0] amDepth,
    input wire logic txOutputHold
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic strobe, fmWr, lockWr, mapped;
    assign strobe = regWrite || regRead;
    assign fmWr = regWrite && regAddr == `LDC_OFF_FM;
    assign lockWr = fmWr || (regWrite && regAddr == `LDC_OFF_AM);
    assign mapped = regAddr inside {[`LDC_OFF_CONTROL:`LDC_OFF_AM],
                                    [`LDC_OFF_STATUS:`LDC_OFF_NV_CTRL]};
    chk_resp_next: assert property (strobe |=> respValid)
        else $error("no response after strobe");
    chk_resp_cause: assert property (respValid |-> $past(strobe))
        else $error("response without strobe");
    chk_error_zero: assert property (respError |-> regRdata == 16'h0000)
        else $error("error response with nonzero data");
    chk_fm_apply: assert property (fmWr ##1 !respError |=>
        fmDeviation == $past(regWdata, 2))
        else $error("accepted deviation not applied");
    chk_range_error: assert property (lockWr && regWdata >
        (fmWr ? `LDC_FM_MAX : `LDC_AM_MAX) |=> respError)
        else $error("unsupported value accepted");
    chk_lock_while_on: assert property (ditherOn && fmWr &&
        regWdata <= `LDC_FM_MAX |=> respError && respCause == LDC_ERR_ENABLED)
        else $error("write accepted while dither on");
    chk_unmapped_error: assert property (strobe && !mapped |=>
        respError && respCause == LDC_ERR_UNMAPPED)
        else $error("unmapped access not refused");
    chk_wave_legal: assert property (waveSelect <= `LDC_WAVE_TRI)
        else $error("illegal waveform selected");
    chk_rate_step: assert property (toneRate >= `LDC_RATE_MIN &&
        toneRate <= `LDC_RATE_MAX && toneRate % `LDC_RATE_STEP == 0)
        else $error("rate off the supported steps");
    chk_both_set: assert property ((amDepth != 0 && fmDeviation != 0)[*2]
        |-> suppressRate == `LDC_SBS_RATE)
        else $error("suppression not at default rate");
    chk_output_hold: assert property (txOutputHold)
        else $error("optical output interrupted");
endmodule // ldc_properties
bind ldc_laser_dither_config ldc_properties chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .respValid(respValid), .respError(respError), .respCause(respCause),
    .ditherOn(ditherOn), .waveSelect(waveSelect), .toneRate(toneRate),
    .suppressRate(suppressRate), .fmDeviation(fmDeviation),
    .amDepth(amDepth), .txOutputHold(txOutputHold));
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the dither register bank
// Assumes: Host model drives the register port
// Notes:   Table rows first, then deferred writes, irq and reset
`timescale 1ns/1ns
`default_nettype none
`include "ldc_cfg.svh"
module tb
    import ldc_pkg::*;
;
    typedef struct packed {
        logic wr; logic [7:0] addr; logic [15:0] data;
        logic err; logic [2:0] cause; logic [15:0] rdata;
    } ldc_tb_row_t;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata, nvRate = 16'h0064;
    logic regWrite, regRead, respValid, respError, respPending, irq;
    logic ditherOn, nvSave, txOutputHold;
    logic [2:0] respCause;
    logic [1:0] waveSelect;
    logic [15:0] toneRate, suppressRate, fmDeviation, amDepth;
    int bad_count = 0, cmp_count = 0, cycles = 0;
    ldc_tb_row_t rows[13] = '{
        '{1'h0, 8'h59, 16'h0000, 1'h0, 3'h0, 16'h0010},
        '{1'h0, 8'h5A, 16'h0000, 1'h0, 3'h0, 16'h0064},
        '{1'h0, 8'h5B, 16'h0000, 1'h0, 3'h0, 16'h0000},
        '{1'h0, 8'h5C, 16'h0000, 1'h0, 3'h0, 16'h0032},
        '{1'h1, 8'h5B, 16'h0005, 1'h0, 3'h0, 16'h0005},
        '{1'h1, 8'h5B, 16'h000B, 1'h1, 3'h3, 16'h0000},
        '{1'h1, 8'h5C, 16'h0065, 1'h1, 3'h3, 16'h0000},
        '{1'h1, 8'h5C, 16'h0064, 1'h0, 3'h0, 16'h0064},
        '{1'h0, 8'h5B, 16'h0000, 1'h0, 3'h0, 16'h0005},
        '{1'h1, 8'h70, 16'h0001, 1'h1, 3'h1, 16'h0000},
        '{1'h0, 8'h50, 16'h0000, 1'h1, 3'h5, 16'h0000},
        '{1'h1, 8'h59, 16'h0040, 1'h1, 3'h3, 16'h0000},
        '{1'h1, 8'h59, 16'h0032, 1'h1, 3'h3, 16'h0000}};
    always #5 clk_sys = ~clk_sys;
    ldc_host_model host (.clk_sys(clk_sys), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .respValid(respValid), .respError(respError),
        .respCause(respCause), .respPending(respPending));
    ldc_laser_dither_config uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .respValid(respValid),
        .respError(respError), .respCause(respCause),
        .respPending(respPending), .nvControl(16'h0010), .nvRate(nvRate),
        .nvFm(16'h0000), .nvAm(16'h0032), .nvSave(nvSave),
        .ditherOn(ditherOn),
        .waveSelect(waveSelect), .toneRate(toneRate),
        .suppressRate(suppressRate), .fmDeviation(fmDeviation),
        .amDepth(amDepth), .txOutputHold(txOutputHold), .irq(irq));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, input logic e,
                       input logic [2:0] c, input logic [15:0] r);
        host.access(wr, a, d);
        check(host.gotData, r);
        check(16'(host.gotErr), 16'(e));
        check(16'(host.gotCause), 16'(c));
        check(16'(host.gotValid), 16'h0001);
        check(16'(host.gotPend), 16'h0000);
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].addr, rows[i].data, rows[i].err,
                rows[i].cause, rows[i].rdata);
        end
        check(suppressRate, `LDC_SBS_RATE);
        check(fmDeviation, 16'h0005);
        check(amDepth, 16'h0064);
        check(16'(irq), 16'h0000);
        acc(1'h1, 8'h72, 16'h0002, 1'h0, 3'h0, 16'h0002);
        host.access(1'h1, 8'h5A, 16'h0067);
        check(16'(host.gotPend), 16'h0001);
        check(host.gotData, 16'h0001);
        acc(1'h1, 8'h5A, 16'h0064, 1'h1, 3'h2, 16'h0000);
        repeat (12) @(posedge clk_sys);
        check(16'(irq), 16'h0001);
        acc(1'h0, 8'h5A, 16'h0000, 1'h0, 3'h0, 16'h0069);
        check(toneRate, 16'h0069);
        acc(1'h1, 8'h71, 16'h0002, 1'h0, 3'h0, 16'h0002);
        check(16'(irq), 16'h0000);
        acc(1'h1, 8'h73, 16'h0001, 1'h0, 3'h0, 16'h0001);
        check(16'(nvSave), 16'h0001);
        acc(1'h0, 8'h71, 16'h0000, 1'h0, 3'h0, 16'h0005);
        host.access(1'h1, 8'h59, 16'h0012);
        check(16'(host.gotPend), 16'h0001);
        check(host.gotData, 16'h0002);
        repeat (12) @(posedge clk_sys);
        check(16'(ditherOn), 16'h0001);
        check(16'(txOutputHold), 16'h0001);
        check(16'(waveSelect), 16'(`LDC_WAVE_TRI));
        acc(1'h1, 8'h5B, 16'h0003, 1'h1, 3'h4, 16'h0000);
        acc(1'h1, 8'h5C, 16'h0005, 1'h1, 3'h4, 16'h0000);
        host.access(1'h1, 8'h59, 16'h0000);
        repeat (12) @(posedge clk_sys);
        check(16'(ditherOn), 16'h0000);
        acc(1'h1, 8'h5B, 16'h0000, 1'h0, 3'h0, 16'h0000);
        @(posedge clk_sys);
        nvRate <= 16'h00C8;
        rst_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(toneRate, 16'h0064);
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        acc(1'h0, 8'h5A, 16'h0000, 1'h0, 3'h0, 16'h00C8);
        finish_test();
    end
endmodule // tb
`default_nettype wire
